// >>> include/wrt_pkg.sv
// package for the wireless receiver tuning register bank
// assumes a byte-addressed host port; wide registers occupy consecutive bytes
package wrt_pkg;
    // register byte offsets
    localparam logic [15:0] ADDR_TX_CLR_0      = 16'h0028; // clear bits 7:0
    localparam logic [15:0] ADDR_TX_CLR_1      = 16'h0029; // clear bits 15:8
    localparam logic [15:0] ADDR_TX_CLR_2      = 16'h002a; // clear bits 23:16
    localparam logic [15:0] ADDR_TX_CLR_3      = 16'h002b; // clear bits 31:24
    localparam logic [15:0] ADDR_TX_INT_0      = 16'h0030; // flag bits 7:0
    localparam logic [15:0] ADDR_TX_INT_1      = 16'h0031; // flag bits 15:8
    localparam logic [15:0] ADDR_TX_INT_2      = 16'h0032; // flag bits 23:16
    localparam logic [15:0] ADDR_TX_INT_3      = 16'h0033; // flag bits 31:24
    localparam logic [15:0] ADDR_EPT_REASON    = 16'h0034; // end-transfer reason
    localparam logic [15:0] ADDR_REQ_GP        = 16'h00bd;
    localparam logic [15:0] ADDR_QFACTOR       = 16'h00d2;
    localparam logic [15:0] ADDR_SIG_STRENGTH  = 16'h00d3;
    localparam logic [15:0] ADDR_CLAMP_SINK    = 16'h00f9;
    localparam logic [15:0] ADDR_OC_THR_LO     = 16'h010c;
    localparam logic [15:0] ADDR_OC_THR_HI     = 16'h010d;
    localparam logic [15:0] ADDR_OC_HYST       = 16'h010e;
    localparam logic [15:0] ADDR_KNEE          = 16'h0142;
    localparam logic [15:0] ADDR_CORR_COEF     = 16'h0143;
    localparam logic [15:0] ADDR_HR_MAX_LO     = 16'h0144;
    localparam logic [15:0] ADDR_HR_MAX_HI     = 16'h0145;
    localparam logic [15:0] ADDR_HR_MIN_LO     = 16'h0146;
    localparam logic [15:0] ADDR_HR_MIN_HI     = 16'h0147;
    localparam logic [15:0] ADDR_SECTION_IDX   = 16'h0149;
    localparam logic [15:0] ADDR_FINAL_ADJ     = 16'h014e;
    localparam logic [15:0] ADDR_OC_STATUS     = 16'h0150; // over-current status
    // reset values
    localparam logic [7:0]  RST_REQ_GP         = 8'h1e;
    localparam logic [7:0]  RST_QFACTOR        = 8'h53;
    localparam logic [7:0]  RST_CLAMP_SINK     = 8'h1f;
    localparam logic [7:0]  CLAMP_SINK_MAX     = 8'h1f;  // highest valid code
    localparam logic [15:0] RST_OC_THR         = 16'h0dac;
    localparam logic [7:0]  RST_OC_HYST        = 8'hc8;
    localparam logic [7:0]  RST_KNEE_BPP       = 8'h19;  // 25
    localparam logic [7:0]  RST_KNEE_EPP       = 8'h32;  // 50
    localparam logic [7:0]  RST_CORR_BPP       = 8'h0c;  // 12
    localparam logic [7:0]  RST_CORR_EPP       = 8'h04;  // 4
    localparam logic [15:0] RST_HR_MAX         = 16'h00c3; // 195
    localparam logic [15:0] RST_HR_MIN         = 16'h0000;
    localparam logic [7:0]  RST_BYTE           = 8'h00;
    localparam logic [31:0] RST_WORD           = 32'h0000_0000;
    // implemented clear and flag bit positions
    localparam logic [31:0] TX_BITS_MASK       = 32'h0007_e1ff;
    localparam int          TX_BITS            = 32;
    // end-power-transfer reason code sent on over-current
    localparam logic [7:0]  EPT_REASON_OC      = 8'h04;
    // sink current scale in mA per code step
    localparam int          CLAMP_SINK_MA_STEP = 7;
    // clamp overvoltage modes
    typedef enum logic [1:0] {
        WRT_CLAMP_OFF = 2'b00, // clamp idle
        WRT_CLAMP_CV  = 2'b01, // constant-voltage clamp
        WRT_CLAMP_CC  = 2'b10  // constant-current clamp
    } wrt_clamp_mode_e;
endpackage : wrt_pkg

// >>> hdl/wrt_oc_monitor.sv
// over-current comparator stage for the tuning register bank
// assumes one current sample per valid pulse, on the system clock
module wrt_oc_monitor
    import wrt_pkg::*;
#(
    parameter int CUR_W = 16                // current sample width
) (
    input  wire logic             i_clk_sys,     // system clock
    input  wire logic             i_rst_b,       // synchronous reset, low
    input  wire logic             i_cur_valid,   // new sample strobe
    input  wire logic [CUR_W-1:0] i_cur_sample,  // measured output current
    input  wire logic [15:0]      i_threshold,   // over-current threshold
    input  wire logic [7:0]       i_hysteresis,  // extra margin for shutdown
    output logic                  o_fault_pulse, // one-cycle fault pulse
    output logic                  o_ept_pulse    // one-cycle end-transfer pulse
);
    logic [16:0] upper_limit; // threshold plus hysteresis, no wrap

    // widen before adding so the upper limit never wraps
    assign upper_limit = {1'b0, i_threshold} + {9'h000, i_hysteresis};

    // compare only on fresh samples
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_fault_pulse <= 1'b0;
            o_ept_pulse   <= 1'b0;
        end else begin
            o_fault_pulse <= i_cur_valid && (17'(i_cur_sample) > {1'b0, i_threshold});
            o_ept_pulse   <= i_cur_valid && (17'(i_cur_sample) > upper_limit);
        end
    end
endmodule : wrt_oc_monitor

// >>> hdl/wrt_vrect_target.sv
// rectifier target calculation: base plus headroom, bounded, then adjusted
// assumes the inputs are stable registers on the system clock
module wrt_vrect_target
    import wrt_pkg::*;
(
    input  wire logic        i_clk_sys,    // system clock
    input  wire logic        i_rst_b,      // synchronous reset, low
    input  wire logic [15:0] i_vout_code,  // output voltage in adc codes
    input  wire logic [15:0] i_out_power,  // output power, 0.1 w units
    input  wire logic [7:0]  i_knee,       // power knee threshold
    input  wire logic [7:0]  i_coef,       // correction coefficient
    input  wire logic [15:0] i_hr_max,     // headroom upper bound
    input  wire logic [15:0] i_hr_min,     // headroom lower bound
    input  wire logic [7:0]  i_adjust,     // signed final adjustment
    output logic [15:0]      o_target      // rectifier target in adc codes
);
    logic [15:0] raw_hr;     // headroom before bounding
    logic [15:0] bound_hr;   // headroom after bounding
    logic [17:0] sum_full;   // signed sum with guard bits

    // headroom shrinks to the minimum above the knee
    always_comb begin
        if (i_out_power > {8'h00, i_knee}) begin
            raw_hr = i_hr_min;
        end else begin
            raw_hr = 16'(({8'h00, i_coef} * 16'(i_knee)) - 16'(i_out_power));
        end
        if (raw_hr > i_hr_max) begin
            bound_hr = i_hr_max;
        end else if (raw_hr < i_hr_min) begin
            bound_hr = i_hr_min;
        end else begin
            bound_hr = raw_hr;
        end
        sum_full = {2'b00, i_vout_code} + {2'b00, bound_hr}
                 + {{10{i_adjust[7]}}, i_adjust};
    end

    // saturate to the 16-bit range
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_target <= 16'h0000;
        end else if (sum_full[17]) begin
            o_target <= 16'h0000;
        end else if (sum_full[16]) begin
            o_target <= 16'hffff;
        end else begin
            o_target <= sum_full[15:0];
        end
    end
endmodule : wrt_vrect_target

// >>> hdl/wrt_reg_bank.sv
// host register bank for receiver tuning and transmit interrupt clearing
// assumes a byte-wide host port on the system clock; firmware-side status
// values and events arrive as same-clock inputs
//
// Summary of operation
// - guaranteed power request, half watt units
// - quality factor reported during negotiation
// - sink current used only in cc overvoltage
// - sink current 7 mA/step, max 0x1f
// - current above threshold raises fault
// - above threshold plus margin ends transfer
// - knee threshold selects minimal window
// - correction coefficient in target calculation
// - headroom limited by maximum
// - headroom limited by minimum
// - read-only detection section index
// - signed final adjustment past bounds
// - host writes one, bit self-clears
// - clear bits 18:13, 8:0; others reserved
// - upper clear bit event mapping
// - lower clear bit event mapping
// - read-only signal strength value
// - flag register mirrors clear bit layout
// - bit 0 error, reason register
//
// Design decision made here: the strobed register port.
module wrt_reg_bank
    import wrt_pkg::*;
#(
    parameter int CUR_W = 16                        // current sample width
) (
    input  wire logic             i_clk_sys,        // system clock, 50 MHz
    input  wire logic             i_rst_b,          // synchronous reset, low
    // host register port
    input  wire logic [15:0]      i_addr,           // byte address
    input  wire logic [7:0]       i_wdata,          // write data
    input  wire logic             i_wr,             // write strobe
    input  wire logic             i_rd,             // read strobe
    output logic [7:0]            o_rdata,          // read data, next cycle
    // profile strap, same clock
    input  wire logic             i_profile_epp,    // 1 = extended profile
    // firmware-side status values
    input  wire logic [7:0]       i_sig_strength,   // measured signal strength
    input  wire logic [7:0]       i_section_idx,    // last section index used
    input  wire logic             i_section_valid,  // section index update
    input  wire logic [7:0]       i_final_adjust,   // signed final adjustment
    input  wire logic             i_adjust_valid,   // adjustment update
    input  wire logic [TX_BITS-1:0] i_tx_events,    // transmit event pulses
    // clamp status
    input  wire logic [1:0]       i_clamp_mode,     // clamp overvoltage mode
    input  wire logic             i_overvoltage,    // overvoltage present
    // current measurement
    input  wire logic             i_cur_valid,      // new current sample
    input  wire logic [CUR_W-1:0] i_cur_sample,     // measured current
    // target calculation inputs
    input  wire logic [15:0]      i_vout_code,      // output voltage code
    input  wire logic [15:0]      i_out_power,      // output power, 0.1 w
    // outputs toward the firmware and link
    output logic [7:0]            o_req_gp,         // requested power, 0.5 w
    output logic [7:0]            o_qfactor,        // reported quality factor
    output logic [7:0]            o_clamp_sink,     // applied sink current code
    output logic                  o_clamp_sink_en,  // sink current active
    output logic                  o_oc_fault,       // fault interrupt pulse
    output logic                  o_ept_send,       // end-transfer request pulse
    output logic [7:0]            o_ept_reason,     // end-transfer reason
    output logic [TX_BITS-1:0]    o_tx_int,         // transmit interrupt flags
    output logic [15:0]           o_vrect_target    // rectifier target
);
    // writable settings
    logic [7:0]          req_gp_q;        // requested guaranteed power
    logic [7:0]          qfactor_q;       // quality factor
    logic [7:0]          clamp_sink_q;    // sink current code
    logic [15:0]         oc_thr_q;        // over-current threshold
    logic [7:0]          oc_hyst_q;       // over-current margin
    logic [7:0]          knee_q;          // power knee
    logic [7:0]          corr_q;          // correction coefficient
    logic [15:0]         hr_max_q;        // headroom maximum
    logic [15:0]         hr_min_q;        // headroom minimum
    // status captured from the firmware side
    logic [7:0]          section_q;       // detection section index
    logic [7:0]          adjust_q;        // final adjustment
    logic [7:0]          sig_q;           // signal strength
    logic [TX_BITS-1:0]  tx_clr_q;        // clear register
    logic [TX_BITS-1:0]  tx_int_q;        // interrupt flags
    logic [7:0]          ept_reason_q;    // last end-transfer reason
    logic [1:0]          oc_sticky_q;     // {ept seen, fault seen}
    logic                init_q;          // defaults loaded after reset
    logic [7:0]          rdata_q;         // read data register
    // comparator pulses
    logic                fault_pulse;     // above threshold
    logic                ept_pulse;       // above threshold plus margin
    logic [7:0]          rd_mux;          // combinational read value

    // write hit decoder shared by the settings write processes; clear bits decode their own writes
    function automatic logic wr_hit(input logic [15:0] a);
        wr_hit = i_wr && (i_addr == a);
    endfunction : wr_hit

    // byte lane select from a 32-bit word
    function automatic logic [7:0] lane(input logic [31:0] w, input logic [1:0] s);
        lane = w[8*s +: 8];
    endfunction : lane

    // first cycle after reset release loads profile defaults
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            init_q <= 1'b1;
        end else begin
            init_q <= 1'b0;
        end
    end

    // profile-independent settings
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            req_gp_q   <= RST_REQ_GP;
            qfactor_q  <= RST_QFACTOR;
            clamp_sink_q <= RST_CLAMP_SINK;
            oc_thr_q   <= RST_OC_THR;
            oc_hyst_q  <= RST_OC_HYST;
            hr_max_q   <= RST_HR_MAX;
            hr_min_q   <= RST_HR_MIN;
        end else begin
            if (wr_hit(ADDR_REQ_GP)) begin
                req_gp_q <= i_wdata;
            end
            if (wr_hit(ADDR_QFACTOR)) begin
                qfactor_q <= i_wdata;
            end
            if (wr_hit(ADDR_CLAMP_SINK)) begin
                clamp_sink_q <= (i_wdata > CLAMP_SINK_MAX) ? CLAMP_SINK_MAX : i_wdata;
            end
            if (wr_hit(ADDR_OC_THR_LO)) begin
                oc_thr_q[7:0] <= i_wdata;
            end
            if (wr_hit(ADDR_OC_THR_HI)) begin
                oc_thr_q[15:8] <= i_wdata;
            end
            if (wr_hit(ADDR_OC_HYST)) begin
                oc_hyst_q <= i_wdata;
            end
            if (wr_hit(ADDR_HR_MAX_LO)) begin
                hr_max_q[7:0] <= i_wdata;
            end
            if (wr_hit(ADDR_HR_MAX_HI)) begin
                hr_max_q[15:8] <= i_wdata;
            end
            if (wr_hit(ADDR_HR_MIN_LO)) begin
                hr_min_q[7:0] <= i_wdata;
            end
            if (wr_hit(ADDR_HR_MIN_HI)) begin
                hr_min_q[15:8] <= i_wdata;
            end
        end
    end

    // profile-dependent settings, strap sampled just after reset release
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            knee_q <= RST_KNEE_BPP;
            corr_q <= RST_CORR_BPP;
        end else if (init_q) begin
            knee_q <= i_profile_epp ? RST_KNEE_EPP : RST_KNEE_BPP;
            corr_q <= i_profile_epp ? RST_CORR_EPP : RST_CORR_BPP;
        end else begin
            if (wr_hit(ADDR_KNEE)) begin
                knee_q <= i_wdata;
            end
            if (wr_hit(ADDR_CORR_COEF)) begin
                corr_q <= i_wdata;
            end
        end
    end

    // read-only status captured from firmware
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            section_q <= RST_BYTE;
            adjust_q  <= RST_BYTE;
            sig_q     <= RST_BYTE;
        end else begin
            if (i_section_valid) begin
                section_q <= i_section_idx;
            end
            if (i_adjust_valid) begin
                adjust_q <= i_final_adjust;
            end
            sig_q <= i_sig_strength;
        end
    end

    // clear register and interrupt flags, one bit slice per position
    genvar gi;
    generate
        for (gi = 0; gi < TX_BITS; gi++) begin : g_tx
            if (TX_BITS_MASK[gi]) begin : g_impl
                // host write of one to this bit
                logic clr_wr;
                assign clr_wr = i_wr && (i_addr[15:2] == ADDR_TX_CLR_0[15:2])
                             && (i_addr[1:0] == 2'(gi / 8)) && i_wdata[gi % 8];
                always_ff @(posedge i_clk_sys) begin
                    if (!i_rst_b) begin
                        tx_clr_q[gi] <= 1'b0;
                        tx_int_q[gi] <= 1'b0;
                    end else begin
                        tx_clr_q[gi] <= clr_wr;
                        if (i_tx_events[gi]) begin
                            tx_int_q[gi] <= 1'b1;
                        end else if (tx_clr_q[gi]) begin
                            tx_int_q[gi] <= 1'b0;
                        end
                    end
                end
            end else begin : g_rsvd
                assign tx_clr_q[gi] = 1'b0;
                assign tx_int_q[gi] = 1'b0;
            end
        end
    endgenerate

    // over-current comparator
    wrt_oc_monitor #(
        .CUR_W (CUR_W)
    ) u_oc (
        .i_clk_sys     (i_clk_sys),
        .i_rst_b       (i_rst_b),
        .i_cur_valid   (i_cur_valid),
        .i_cur_sample  (i_cur_sample),
        .i_threshold   (oc_thr_q),
        .i_hysteresis  (oc_hyst_q),
        .o_fault_pulse (fault_pulse),
        .o_ept_pulse   (ept_pulse)
    );

    // sticky over-current status and end-transfer reason
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            oc_sticky_q  <= 2'b00;
            ept_reason_q <= RST_BYTE;
        end else begin
            // event wins over a read-clear in the same cycle
            oc_sticky_q <= {ept_pulse, fault_pulse}
                         | ((i_rd && (i_addr == ADDR_OC_STATUS)) ? 2'b00 : oc_sticky_q);
            if (ept_pulse) begin
                ept_reason_q <= EPT_REASON_OC;
            end
        end
    end

    // target calculation
    wrt_vrect_target u_vt (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_vout_code (i_vout_code),
        .i_out_power (i_out_power),
        .i_knee      (knee_q),
        .i_coef      (corr_q),
        .i_hr_max    (hr_max_q),
        .i_hr_min    (hr_min_q),
        .i_adjust    (adjust_q),
        .o_target    (o_vrect_target)
    );

    // read multiplexer
    always_comb begin
        case (i_addr)
            ADDR_TX_CLR_0, ADDR_TX_CLR_1,
            ADDR_TX_CLR_2, ADDR_TX_CLR_3:  rd_mux = lane(tx_clr_q, i_addr[1:0]);
            ADDR_TX_INT_0, ADDR_TX_INT_1,
            ADDR_TX_INT_2, ADDR_TX_INT_3:  rd_mux = lane(tx_int_q, i_addr[1:0]);
            ADDR_EPT_REASON:   rd_mux = ept_reason_q;
            ADDR_REQ_GP:       rd_mux = req_gp_q;
            ADDR_QFACTOR:      rd_mux = qfactor_q;
            ADDR_SIG_STRENGTH: rd_mux = sig_q;
            ADDR_CLAMP_SINK:   rd_mux = clamp_sink_q;
            ADDR_OC_THR_LO:    rd_mux = oc_thr_q[7:0];
            ADDR_OC_THR_HI:    rd_mux = oc_thr_q[15:8];
            ADDR_OC_HYST:      rd_mux = oc_hyst_q;
            ADDR_KNEE:         rd_mux = knee_q;
            ADDR_CORR_COEF:    rd_mux = corr_q;
            ADDR_HR_MAX_LO:    rd_mux = hr_max_q[7:0];
            ADDR_HR_MAX_HI:    rd_mux = hr_max_q[15:8];
            ADDR_HR_MIN_LO:    rd_mux = hr_min_q[7:0];
            ADDR_HR_MIN_HI:    rd_mux = hr_min_q[15:8];
            ADDR_SECTION_IDX:  rd_mux = section_q;
            ADDR_FINAL_ADJ:    rd_mux = adjust_q;
            ADDR_OC_STATUS:    rd_mux = {6'h00, oc_sticky_q};
            // unmapped addresses read zero
            default:           rd_mux = RST_BYTE;
        endcase
    end

    // read data register, valid the cycle after the strobe only
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            rdata_q <= RST_BYTE;
        end else if (i_rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= RST_BYTE;
        end
    end

    // sink current only in cc overvoltage
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_clamp_sink_en <= 1'b0;
            o_clamp_sink    <= RST_BYTE;
        end else begin
            o_clamp_sink_en <= (i_clamp_mode == WRT_CLAMP_CC) && i_overvoltage;
            o_clamp_sink    <= ((i_clamp_mode == WRT_CLAMP_CC) && i_overvoltage)
                             ? clamp_sink_q : RST_BYTE;
        end
    end

    // output wiring
    assign o_rdata      = rdata_q;
    assign o_req_gp     = req_gp_q;
    assign o_qfactor    = qfactor_q;
    assign o_oc_fault   = fault_pulse;
    assign o_ept_send   = ept_pulse;
    assign o_ept_reason = ept_reason_q;
    assign o_tx_int     = tx_int_q;
endmodule : wrt_reg_bank

// >>> tb/wrt_chk_monitor.sv
// port checker for the tuning register bank
// assumes one system clock and a synchronous active-low reset
module wrt_chk
    import wrt_pkg::*;
(
    input wire logic        i_clk_sys, i_rst_b, i_wr, i_rd, i_overvoltage, i_cur_valid,
    input wire logic        o_clamp_sink_en, o_oc_fault, o_ept_send,
    input wire logic [15:0] i_addr,
    input wire logic [7:0]  i_wdata, o_rdata, o_req_gp, o_clamp_sink, o_ept_reason,
    input wire logic [1:0]  i_clamp_mode,
    input wire logic [31:0] i_tx_events, o_tx_int
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);
    gp_read_a: assert property (i_rd && i_addr == ADDR_REQ_GP |=> o_rdata == $past(o_req_gp))
        else $error("requested power read mismatch");
    sink_gate_a: assert property ($past(i_rst_b) |-> o_clamp_sink_en ==
        ($past(i_clamp_mode) == WRT_CLAMP_CC && $past(i_overvoltage)))
        else $error("sink enable not tied to cc overvoltage");
    sink_off_a: assert property (!o_clamp_sink_en |-> o_clamp_sink == 8'h00)
        else $error("sink code applied while inactive");
    sink_max_a: assert property (o_clamp_sink <= CLAMP_SINK_MAX)
        else $error("sink code above maximum");
    ept_fault_a: assert property (o_ept_send |-> o_oc_fault)
        else $error("end transfer without fault");
    fault_src_a: assert property (o_oc_fault |-> $past(i_cur_valid))
        else $error("fault without a new sample");
    ept_reason_a: assert property ($rose(o_ept_send) |=> o_ept_reason == EPT_REASON_OC)
        else $error("end transfer reason wrong");
    tx_rsvd_a: assert property ((o_tx_int & ~TX_BITS_MASK) == 32'h0000_0000)
        else $error("reserved flag bit set");
    tx_set_a: assert property ($past(i_rst_b) |->
        ($past(i_tx_events) & TX_BITS_MASK & ~o_tx_int) == 32'h0000_0000)
        else $error("event did not set its flag");
    tx_clr_a: assert property (i_wr && i_addr == ADDR_TX_CLR_0 && i_wdata[0] ##1
        !i_tx_events[0] [*2] |=> !o_tx_int[0]) else $error("flag bit 0 not cleared");
endmodule : wrt_chk
bind wrt_reg_bank wrt_chk chk_u (.i_clk_sys, .i_rst_b, .i_wr, .i_rd, .i_overvoltage,
    .i_cur_valid, .o_clamp_sink_en, .o_oc_fault, .o_ept_send, .i_addr, .i_wdata, .o_rdata,
    .o_req_gp, .o_clamp_sink, .o_ept_reason, .i_clamp_mode, .i_tx_events, .o_tx_int);

// >>> tb/wrt_host_model.sv
// host processor model driving the byte register port
// assumes its tasks are called from one bench thread
module wrt_host_model (
    input  wire logic       i_clk_sys,       // system clock
    input  wire logic [7:0] i_rdata,         // read data, cycle after strobe
    output logic [15:0]     o_addr = 16'h0000, // byte address
    output logic [7:0]      o_wdata = 8'h00, // write data
    output logic            o_wr = 1'b0,     // write strobe
    output logic            o_rd = 1'b0      // read strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge i_clk_sys);
        {o_addr, o_wdata, o_wr} <= {a, v, 1'b1};
        @(posedge i_clk_sys);
        {o_addr, o_wdata, o_wr} <= {~a, ~v, 1'b0};
    endtask : wr
    // one-cycle read, data taken the next cycle
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge i_clk_sys);
        {o_addr, o_rd} <= {a, 1'b1};
        @(posedge i_clk_sys);
        {o_addr, o_rd} <= {~a, 1'b0};
        #1 v = i_rdata;
    endtask : rd
endmodule : wrt_host_model

// >>> tb/wireless_rx_tuning_and_tx_irq_clear_tb.sv
// bench for the tuning register bank: registers, monitor, clamp, flags
// assumes the host model owns the register port
module wireless_rx_tuning_and_tx_irq_clear_tb
    import wrt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk_sys = 0, i_rst_b = 0, i_wr, i_rd, i_profile_epp = 0, i_section_valid = 0;
    logic i_adjust_valid = 0, i_overvoltage = 0, i_cur_valid = 0, o_clamp_sink_en;
    logic o_oc_fault, o_ept_send;
    logic [15:0] i_addr, i_cur_sample = 0, i_vout_code = 0, i_out_power = 0, o_vrect_target;
    logic [7:0] i_wdata, o_rdata, i_sig_strength = 0, i_section_idx = 0, i_final_adjust = 0;
    logic [7:0] o_req_gp, o_qfactor, o_clamp_sink, o_ept_reason, d, w;
    logic [1:0] i_clamp_mode = 0;
    logic [31:0] i_tx_events = 0, o_tx_int, ex;
    int fail_count = 0, checked = 0, seed = 48852, cyc = 0;
    logic [15:0] ra[14] = '{ADDR_REQ_GP, ADDR_QFACTOR, ADDR_CLAMP_SINK, ADDR_OC_THR_LO,
        ADDR_OC_THR_HI, ADDR_OC_HYST, ADDR_KNEE, ADDR_CORR_COEF, ADDR_HR_MAX_LO,
        ADDR_HR_MAX_HI, ADDR_HR_MIN_LO, ADDR_SECTION_IDX, ADDR_TX_CLR_0, 16'h0100};
    logic [7:0] rv[14] = '{8'h1e, 8'h53, 8'h1f, 8'hac, 8'h0d, 8'hc8, 8'h19, 8'h0c,
        8'hc3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    wrt_reg_bank dut_u (.*);
    wrt_host_model host_u (.i_clk_sys, .i_rdata(o_rdata), .o_addr(i_addr),
        .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
    always #10 i_clk_sys = ~i_clk_sys;
    // free-running target inputs and timeout
    always @(posedge i_clk_sys) begin
        {i_vout_code, i_out_power} <= $random(seed);
        {i_final_adjust, i_adjust_valid} <= 9'($random(seed));
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rc(input logic [15:0] a, input logic [7:0] e);
        host_u.rd(a, d);
        chk("read data", d, e);
    endtask : rc
    // clamp writes above the maximum code
    function automatic logic [7:0] expv(int k, logic [7:0] v);
        return (k == 2 && v > 8'h1f) ? 8'h1f : v;
    endfunction : expv
    task automatic oc(input logic [15:0] s, input logic f, e);
        @(posedge i_clk_sys);
        {i_cur_valid, i_cur_sample} <= {1'b1, s};
        @(posedge i_clk_sys);
        i_cur_valid <= 1'b0;
        #1 chk("fault", o_oc_fault, f);
        chk("end transfer", o_ept_send, e);
    endtask : oc
    task automatic close_out();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    initial begin
        i_sig_strength <= $random(seed);
        repeat (8) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        foreach (ra[k]) rc(ra[k], rv[k]);
        rc(ADDR_SIG_STRENGTH, i_sig_strength);
        $display("reset values done");
        oc(16'h0dac, 1'b0, 1'b0);
        oc(16'h0dad, 1'b1, 1'b0);
        oc(16'h0e74, 1'b1, 1'b0);
        oc(16'h0e75, 1'b1, 1'b1);
        @(posedge i_clk_sys) #1 chk("reason", o_ept_reason, EPT_REASON_OC);
        $display("over-current done");
        i_overvoltage <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            i_clamp_mode <= 2'(m);
            repeat (2) @(posedge i_clk_sys);
            #1 chk("sink code", o_clamp_sink, m == 2 ? 8'h1f : 8'h00);
        end
        $display("clamp done");
        @(posedge i_clk_sys) i_tx_events <= 32'hffff_ffff;
        @(posedge i_clk_sys) i_tx_events <= 32'h0000_0000;
        ex = 32'h0007_e1ff;
        for (int b = 0; b < 32; b++) begin
            host_u.wr(ADDR_TX_CLR_0 + 16'(b / 8), 8'(1 << (b % 8)));
            ex[b] = 1'b0;
            @(posedge i_clk_sys) #1 chk("flags", o_tx_int, ex);
            rc(ADDR_TX_CLR_0 + 16'(b / 8), 8'h00);
        end
        $display("flag clear done");
        for (int k = 0; k < 11; k++) begin
            w = $random(seed);
            host_u.wr(ra[k], w);
            rc(ra[k], expv(k, w));
        end
        host_u.wr(ADDR_CLAMP_SINK, 8'h20);
        rc(ADDR_CLAMP_SINK, 8'h1f);
        {i_section_idx, i_section_valid} <= {8'($random(seed)), 1'b1};
        @(posedge i_clk_sys) i_section_valid <= 1'b0;
        host_u.wr(ADDR_SECTION_IDX, ~i_section_idx);
        rc(ADDR_SECTION_IDX, i_section_idx);
        {i_profile_epp, i_rst_b} <= 2'b10;
        @(posedge i_clk_sys) i_rst_b <= 1'b1;
        rc(ADDR_KNEE, RST_KNEE_EPP);
        $display("register access done");
        close_out();
    end
endmodule : wireless_rx_tuning_and_tx_irq_clear_tb
